// ---- core/nvm_pkg.sv ----
package nvm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned STORE_BYTES = 512;
  localparam int unsigned SAVE_TIME_US = 46000;
  localparam int unsigned RESTORE_TIME_US = 40000;
  localparam int unsigned DEFAULTS_TIME_NS = 2000;
  // Per-byte store timing, rounded down so a full pass stays near the figure
  localparam int unsigned SAVE_BYTE_CYC = SAVE_TIME_US * CLK_MHZ / STORE_BYTES;
  localparam int unsigned RESTORE_BYTE_CYC = RESTORE_TIME_US * CLK_MHZ / STORE_BYTES;
  localparam int unsigned DEFAULTS_CYC = DEFAULTS_TIME_NS * CLK_MHZ / 1000;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets and bit positions
  localparam logic [12:0] ADDR_SOFT_RESET = 13'h0000;
  localparam logic [12:0] ADDR_STATUS_SEL = 13'h0232;
  localparam logic [12:0] ADDR_COMMIT = 13'h0234;
  localparam logic [12:0] ADDR_SEG_BASE = 13'h0A00;
  localparam logic [12:0] ADDR_BUSY = 13'h0B00;
  localparam logic [12:0] ADDR_ERROR = 13'h0B01;
  localparam logic [12:0] ADDR_WCTRL = 13'h0B02;
  localparam logic [12:0] ADDR_TRIG = 13'h0B03;
  localparam logic [15:0] ADDR_VCO_CAL = 16'h00F3;
  localparam int unsigned SOFT_RESET_BIT = 5;
  localparam int unsigned STATUS_SEL_BIT = 4;
  localparam int unsigned COMMIT_BIT = 0;
  localparam int unsigned WEN_BIT = 0;
  localparam int unsigned SOFT_LOAD_BIT = 1;
  localparam int unsigned TRIG_BIT = 0;
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned ERROR_BIT = 0;
  localparam int unsigned VCO_CAL_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer segment and opcodes
  localparam int unsigned SEG_BYTES = 23;
  localparam logic [7:0] OP_COMMIT = 8'h80;
  localparam logic [7:0] OP_PSEUDO_END = 8'hFE;
  localparam logic [7:0] OP_END = 8'hFF;
  // Element 0 is the first entry; four groups of 128 and one of 53 cover 0x000 to 0x234
  localparam logic [SEG_BYTES-1:0][7:0] SEG_RESET = {
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h80, 8'h00, 8'h02, 8'h34,
    8'h80, 8'h01, 8'h7F, 8'h00, 8'h01, 8'h7F,
    8'h80, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h7F};

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers and states
  typedef struct packed {
    logic wr;
    logic rd;
    logic [12:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cfg_wr_t;

  typedef enum logic [3:0] {
    ST_BOOT = 4'b0000,
    ST_DEF_WAIT = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_SV_SEG = 4'b0011,
    ST_SV_REG = 4'b0100,
    ST_NV_WAIT = 4'b0101,
    ST_RS_READ = 4'b0110,
    ST_SYNC = 4'b0111
  } ctl_state_t;

  typedef enum logic [1:0] {
    OPN_CONT = 2'b00,
    OPN_END = 2'b01,
    OPN_PAUSE = 2'b10
  } after_op_t;

endpackage : nvm_pkg

// ---- core/nvm_store.sv ----
`timescale 1ns/1ps
module nvm_store #(
  parameter int unsigned DEPTH = 512,
  parameter int unsigned WR_CYC = 8984,
  parameter int unsigned RD_CYC = 7812
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2((WR_CYC > RD_CYC ? WR_CYC : RD_CYC) + 1);

  typedef struct packed {
    logic busy;
    logic we;
    logic [CW-1:0] cnt;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
  } store_st_t;

  store_st_t s_q, s_d;
  // Cell array keeps no reset: content must survive a hard reset
  logic [7:0] mem [DEPTH];

  // One byte per access, taking the slow cell time before done
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy && req) begin
      s_d.busy = 1'b1;
      s_d.we = we;
      s_d.addr = addr;
      s_d.wdata = wdata;
      s_d.cnt = we ? CW'(WR_CYC - 1) : CW'(RD_CYC - 1);
    end else if (s_q.busy) begin
      if (s_q.cnt == '0) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.rdata = s_q.we ? s_q.wdata : mem[s_q.addr];
      end else begin
        s_d.cnt = s_q.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Cell write lands when the access completes
  always_ff @(posedge clk) begin
    if (s_q.busy && s_q.we && s_q.cnt == '0) begin
      mem[s_q.addr] <= s_q.wdata;
    end
  end

  assign done = s_q.done;
  assign rdata = s_q.rdata;

endmodule : nvm_store

// ---- core/nvm_config_save_restore.sv ----
// Contract
// R1 - 512-byte nonvolatile store keeps saved image
// R2 - Registers locked during transfer except busy
// R3 - Busy set at start, cleared at end
// R4 - I2C address NACK while busy
// R5 - Busy mirrored on status pin when selected
// R6 - Save about 46 ms, restore 40 ms
// R7 - Hard reset restores store or defaults
// R8 - Output sync after hard reset reload
// R9 - Outputs start 2 us or 40 ms
// R10 - Host commits, enables write, then triggers
// R11 - Save copies registers and segment; clears trigger
// R12 - Write enable low refuses store writes
// R13 - Error bit set on failed transfer
// R14 - Pin high: restore on reset, soft reset
// R15 - Pin low: soft-load bit starts restore
// R16 - Saved calibrate bit starts VCO calibration
// R17 - Segment defaults cover 0x000 to 0x234
// R18 - Group is count-minus-one, address high, low
// R19 - Segment ends with end opcode after commit
// R20 - Opcode 0x80 commits restored registers
// R21 - Opcode 0xFF ends save and restore
// R22 - Opcode 0xFE pauses save, resumes later
// R23 - Commit bit applies pending serial writes
// R24 - Segment entries handled strictly in order
`timescale 1ns/1ps
module nvm_config_save_restore
  import nvm_pkg::*;
#(
  parameter int unsigned DEPTH = STORE_BYTES,
  parameter int unsigned SAVE_CYC = SAVE_BYTE_CYC,
  parameter int unsigned RESTORE_CYC = RESTORE_BYTE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic boot_sel,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic [15:0] cfg_rd_addr,
  input wire logic [7:0] cfg_rdata,
  output cfg_wr_t cfg_wr,
  output logic cfg_commit,
  output logic defaults_load,
  output logic out_sync,
  output logic out_enable,
  output logic vco_cal_start,
  output logic xfer_busy,
  output logic status_out_pin_a,
  output logic i2c_addr_ack
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    ctl_state_t st;
    logic busy;
    logic err;
    logic wen;
    logic save_to_nvm_trigger;
    logic resume;
    logic status_sel;
    logic [SEG_BYTES-1:0][7:0] seg;
    logic [4:0] seg_idx;
    logic [1:0] hdr;
    logic [7:0] gcnt;
    logic [7:0] cnt;
    logic [15:0] grp_addr;
    logic [AW:0] nv_addr;
    logic saving;
    after_op_t op;
    logic vco_cal;
    logic [7:0] dcnt;
    logic nv_req;
    logic nv_we;
    logic [7:0] nv_wdata;
    logic [7:0] rdata;
    logic [15:0] cfg_rd_addr;
    cfg_wr_t cfg;
    logic commit;
    logic defaults_load;
    logic out_sync;
    logic out_en;
    logic cal_start;
    logic status_pin;
    logic i2c_ack;
  } ctl_t;

  ctl_t s_q, s_d;
  logic nv_done;
  logic [7:0] nv_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Nonvolatile cells

  // R1 - store instance
  // R6 - per-byte timing
  nvm_store #(
    .DEPTH(DEPTH),
    .WR_CYC(SAVE_CYC),
    .RD_CYC(RESTORE_CYC)
  ) u_store (
    .clk(clk),
    .rst_n(rst_n),
    .req(s_q.nv_req),
    .we(s_q.nv_we),
    .addr(s_q.nv_addr[AW-1:0]),
    .wdata(s_q.nv_wdata),
    .done(nv_done),
    .rdata(nv_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Control

  logic soft_rst;
  logic soft_load;
  logic fail;
  logic [7:0] b;
  logic [12:0] seg_off;

  always_comb begin
    s_d = s_q;
    soft_rst = 1'b0;
    soft_load = 1'b0;
    fail = 1'b0;
    b = '0;
    seg_off = reg_req.addr - ADDR_SEG_BASE;
    s_d.nv_req = 1'b0;
    s_d.cfg.wr = 1'b0;
    s_d.commit = 1'b0;
    s_d.defaults_load = 1'b0;
    s_d.out_sync = 1'b0;
    s_d.cal_start = 1'b0;

    // Register writes; ignored wholesale during a transfer
    // R2 - writes locked
    if (reg_req.wr && !s_q.busy) begin
      case (reg_req.addr)
        ADDR_SOFT_RESET: soft_rst = reg_req.wdata[SOFT_RESET_BIT];
        ADDR_STATUS_SEL: s_d.status_sel = reg_req.wdata[STATUS_SEL_BIT];
        // R23 - commit strobe
        ADDR_COMMIT: s_d.commit = reg_req.wdata[COMMIT_BIT];
        ADDR_WCTRL: begin
          s_d.wen = reg_req.wdata[WEN_BIT];
          soft_load = reg_req.wdata[SOFT_LOAD_BIT];
        end
        ADDR_TRIG: s_d.save_to_nvm_trigger = reg_req.wdata[TRIG_BIT];
        default: begin
          if (seg_off < 13'(SEG_BYTES)) begin
            s_d.seg[seg_off[4:0]] = reg_req.wdata;
          end
        end
      endcase
    end

    // Read data one cycle later; only busy is visible mid-transfer
    // R2 - reads locked
    s_d.rdata = '0;
    if (reg_req.rd) begin
      if (reg_req.addr == ADDR_BUSY) begin
        s_d.rdata[BUSY_BIT] = s_q.busy;
      end else if (!s_q.busy) begin
        case (reg_req.addr)
          ADDR_ERROR: s_d.rdata[ERROR_BIT] = s_q.err;
          ADDR_WCTRL: s_d.rdata[WEN_BIT] = s_q.wen;
          ADDR_TRIG: s_d.rdata[TRIG_BIT] = s_q.save_to_nvm_trigger;
          default: begin
            if (seg_off < 13'(SEG_BYTES)) begin
              s_d.rdata = s_q.seg[seg_off[4:0]];
            end
          end
        endcase
      end
    end

    unique case (s_q.st)
      // R7 - reset source choice
      // R14 - restore on boot
      ST_BOOT: begin
        if (boot_sel) begin
          s_d.st = ST_RS_READ;
        end else begin
          s_d.defaults_load = 1'b1;
          s_d.dcnt = 8'(DEFAULTS_CYC - 1);
          s_d.st = ST_DEF_WAIT;
        end
      end
      // R9 - defaults start delay
      ST_DEF_WAIT: begin
        if (s_q.dcnt == '0) begin
          s_d.st = ST_SYNC;
        end else begin
          s_d.dcnt = s_q.dcnt - 8'd1;
        end
      end
      ST_IDLE: begin
        if (soft_rst) begin
          s_d.out_en = 1'b0;
          s_d.st = ST_BOOT;
        // R15 - soft load
        end else if (soft_load && !boot_sel) begin
          s_d.out_en = 1'b0;
          s_d.st = ST_RS_READ;
        end else if (s_q.save_to_nvm_trigger) begin
          // R12 - refuse without enable
          if (!s_q.wen) begin
            s_d.err = 1'b1;
            s_d.save_to_nvm_trigger = 1'b0;
          end else begin
            s_d.saving = 1'b1;
            s_d.busy = 1'b1;
            s_d.err = 1'b0;
            s_d.seg_idx = '0;
            s_d.hdr = '0;
            s_d.cnt = '0;
            // R22 - resume point
            s_d.nv_addr = s_q.resume ? s_q.nv_addr : '0;
            s_d.resume = 1'b0;
            s_d.st = ST_SV_SEG;
          end
        end
      end
      // R11 - copy segment entries
      // R24 - strict order
      ST_SV_SEG: begin
        s_d.op = OPN_CONT;
        if (s_q.cnt != '0) begin
          s_d.cfg_rd_addr = s_q.grp_addr;
          s_d.st = ST_SV_REG;
        end else if (s_q.seg_idx == 5'(SEG_BYTES)) begin
          fail = 1'b1;
        end else begin
          b = s_q.seg[s_q.seg_idx];
          s_d.seg_idx = s_q.seg_idx + 5'd1;
          // R18 - group layout
          unique case (s_q.hdr)
            2'd0: begin
              if (b == OP_END) begin
                s_d.op = OPN_END;
              end else if (b == OP_PSEUDO_END) begin
                s_d.op = OPN_PAUSE;
              end else if (!b[7]) begin
                s_d.gcnt = b + 8'd1;
                s_d.hdr = 2'd1;
              end
            end
            2'd1: begin
              s_d.grp_addr[15:8] = b;
              s_d.hdr = 2'd2;
            end
            default: begin
              s_d.grp_addr[7:0] = b;
              s_d.hdr = 2'd0;
              s_d.cnt = s_q.gcnt;
            end
          endcase
          if (s_q.nv_addr == (AW+1)'(DEPTH)) begin
            fail = 1'b1;
          end else begin
            s_d.nv_req = 1'b1;
            s_d.nv_we = 1'b1;
            s_d.nv_wdata = b;
            s_d.st = ST_NV_WAIT;
          end
        end
      end
      // Register value read back one cycle after its address
      ST_SV_REG: begin
        if (s_q.nv_addr == (AW+1)'(DEPTH)) begin
          fail = 1'b1;
        end else begin
          s_d.nv_req = 1'b1;
          s_d.nv_we = 1'b1;
          s_d.nv_wdata = cfg_rdata;
          s_d.grp_addr = s_q.grp_addr + 16'd1;
          s_d.cnt = s_q.cnt - 8'd1;
          s_d.st = ST_NV_WAIT;
        end
      end
      // R3 - busy raised for restore
      ST_RS_READ: begin
        if (!s_q.busy) begin
          s_d.busy = 1'b1;
          s_d.err = 1'b0;
          s_d.saving = 1'b0;
          s_d.nv_addr = '0;
          s_d.hdr = '0;
          s_d.cnt = '0;
          s_d.vco_cal = 1'b0;
          s_d.nv_req = 1'b1;
          s_d.nv_we = 1'b0;
          s_d.st = ST_NV_WAIT;
        end else if (s_q.nv_addr == (AW+1)'(DEPTH)) begin
          fail = 1'b1;
        end else begin
          s_d.nv_req = 1'b1;
          s_d.nv_we = 1'b0;
          s_d.st = ST_NV_WAIT;
        end
      end
      ST_NV_WAIT: begin
        if (nv_done) begin
          s_d.nv_addr = s_q.nv_addr + (AW+1)'(1);
          b = nv_rdata;
          if (s_q.saving) begin
            unique case (s_q.op)
              OPN_CONT: s_d.st = ST_SV_SEG;
              // R21 - end on save
              OPN_END: begin
                s_d.busy = 1'b0;
                s_d.save_to_nvm_trigger = 1'b0;
                s_d.st = ST_IDLE;
              end
              // R22 - pause and keep address
              default: begin
                s_d.busy = 1'b0;
                s_d.save_to_nvm_trigger = 1'b0;
                s_d.resume = 1'b1;
                s_d.st = ST_IDLE;
              end
            endcase
          end else if (s_q.cnt != '0) begin
            // Restored byte lands in the buffer registers
            s_d.cfg.wr = 1'b1;
            s_d.cfg.addr = s_q.grp_addr;
            s_d.cfg.wdata = b;
            // R16 - note calibrate bit
            if (s_q.grp_addr == ADDR_VCO_CAL) begin
              s_d.vco_cal = b[VCO_CAL_BIT];
            end
            s_d.grp_addr = s_q.grp_addr + 16'd1;
            s_d.cnt = s_q.cnt - 8'd1;
            s_d.st = ST_RS_READ;
          end else begin
            s_d.st = ST_RS_READ;
            unique case (s_q.hdr)
              2'd0: begin
                // R21 - end on restore
                if (b == OP_END || b == OP_PSEUDO_END) begin
                  s_d.busy = 1'b0;
                  s_d.cal_start = s_q.vco_cal;
                  s_d.st = ST_SYNC;
                // R20 - commit opcode
                end else if (b == OP_COMMIT) begin
                  s_d.commit = 1'b1;
                end else if (b[7]) begin
                  fail = 1'b1;
                end else begin
                  s_d.gcnt = b + 8'd1;
                  s_d.hdr = 2'd1;
                end
              end
              2'd1: begin
                s_d.grp_addr[15:8] = b;
                s_d.hdr = 2'd2;
              end
              default: begin
                s_d.grp_addr[7:0] = b;
                s_d.hdr = 2'd0;
                s_d.cnt = s_q.gcnt;
              end
            endcase
          end
        end
      end
      // R8 - sync after reload
      // R9 - outputs released
      ST_SYNC: begin
        s_d.out_sync = 1'b1;
        s_d.out_en = 1'b1;
        s_d.st = ST_IDLE;
      end
    endcase

    // Failed transfer: flag it and drop busy; restores still sync
    // R13 - error flag
    if (fail) begin
      s_d.err = 1'b1;
      s_d.busy = 1'b0;
      s_d.nv_req = 1'b0;
      s_d.save_to_nvm_trigger = 1'b0;
      s_d.st = s_q.saving ? ST_IDLE : ST_SYNC;
    end

    // Pin mirrors taken from next state so they track busy exactly
    // R5 - status pin
    s_d.status_pin = s_d.busy && s_d.status_sel;
    // R4 - address NACK
    s_d.i2c_ack = !s_d.busy;
  end

  // R17 - segment reset image
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= ST_BOOT;
      s_q.seg <= SEG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = s_q.rdata;
  assign cfg_rd_addr = s_q.cfg_rd_addr;
  assign cfg_wr = s_q.cfg;
  assign cfg_commit = s_q.commit;
  assign defaults_load = s_q.defaults_load;
  assign out_sync = s_q.out_sync;
  assign out_enable = s_q.out_en;
  assign vco_cal_start = s_q.cal_start;
  assign xfer_busy = s_q.busy;
  assign status_out_pin_a = s_q.status_pin;
  assign i2c_addr_ack = s_q.i2c_ack;

endmodule : nvm_config_save_restore

// ---- tb/nvm_props.sv ----
`timescale 1ns/1ps
module nvm_props
  import nvm_pkg::*;
#(
  parameter int unsigned DEPTH = STORE_BYTES,
  parameter int unsigned SAVE_CYC = SAVE_BYTE_CYC,
  parameter int unsigned RESTORE_CYC = RESTORE_BYTE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic boot_sel,
  input wire reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] cfg_rd_addr,
  input wire logic [7:0] cfg_rdata,
  input wire cfg_wr_t cfg_wr,
  input wire logic cfg_commit,
  input wire logic defaults_load,
  input wire logic out_sync,
  input wire logic out_enable,
  input wire logic vco_cal_start,
  input wire logic xfer_busy,
  input wire logic status_out_pin_a,
  input wire logic i2c_addr_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Shadow of the status select; writes while busy are dropped
  logic sel_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sel_q <= 1'b0;
    else if (reg_req.wr && reg_req.addr == ADDR_STATUS_SEL && !xfer_busy)
      sel_q <= reg_req.wdata[STATUS_SEL_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_nack_while_busy: assert property (xfer_busy |-> !i2c_addr_ack)
    else $error("address acked during transfer");
  a_ack_on_done: assert property ($fell(xfer_busy) |-> i2c_addr_ack)
    else $error("address not acked after transfer");
  a_status_pin_busy: assert property ((sel_q && xfer_busy) |-> status_out_pin_a)
    else $error("status pin misses busy");
  a_status_pin_idle: assert property (!xfer_busy |-> !status_out_pin_a)
    else $error("status pin high while idle");
  a_locked_reads: assert property ((xfer_busy && reg_req.rd && reg_req.addr != ADDR_BUSY)
    |=> reg_rdata == 8'h00)
    else $error("register readable during transfer");
  a_busy_readback: assert property ((reg_req.rd && reg_req.addr == ADDR_BUSY)
    |=> reg_rdata == {7'h00, $past(xfer_busy)})
    else $error("busy readback wrong");
  a_commit_pulse: assert property ((reg_req.wr && reg_req.addr == ADDR_COMMIT
    && reg_req.wdata[COMMIT_BIT] && !xfer_busy) |=> cfg_commit)
    else $error("commit bit ignored");
  a_restore_in_xfer: assert property (cfg_wr.wr |-> xfer_busy)
    else $error("register write outside transfer");
  a_defaults_delay: assert property (defaults_load |-> ##[199:201] out_sync)
    else $error("defaults start time wrong");
  a_sync_enables: assert property (out_sync |-> ##[0:1] out_enable)
    else $error("outputs not enabled by sync");
endmodule : nvm_props

bind nvm_config_save_restore nvm_props #(.DEPTH(DEPTH), .SAVE_CYC(SAVE_CYC),
  .RESTORE_CYC(RESTORE_CYC)) nvm_props_i (.clk(clk), .rst_n(rst_n), .boot_sel(boot_sel),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .cfg_rd_addr(cfg_rd_addr), .cfg_rdata(cfg_rdata),
  .cfg_wr(cfg_wr), .cfg_commit(cfg_commit), .defaults_load(defaults_load),
  .out_sync(out_sync), .out_enable(out_enable), .vco_cal_start(vco_cal_start),
  .xfer_busy(xfer_busy), .status_out_pin_a(status_out_pin_a), .i2c_addr_ack(i2c_addr_ack));

// ---- tb/host_bank_model.sv ----
`timescale 1ns/1ps
module host_bank_model
  import nvm_pkg::*;
(
  input wire logic clk,
  output reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] cfg_rd_addr,
  output logic [7:0] cfg_rdata,
  input wire cfg_wr_t cfg_wr,
  input wire logic cfg_commit
);
  logic [7:0] bank [0:1023];
  cfg_wr_t wlog [$];
  int commits = 0;
  initial reg_req = '0;
  // Out of range shows a moving pattern so a stray read is not a quiet zero
  assign cfg_rdata = (cfg_rd_addr < 16'h0400) ? bank[cfg_rd_addr[9:0]] : ~cfg_rd_addr[7:0];
  // Log restored bytes in arrival order
  always @(posedge clk) begin
    if (cfg_wr.wr) wlog.push_back(cfg_wr);
    if (cfg_commit) commits++;
  end
  // One request cycle, then the answer one cycle later
  task automatic access(input logic wr, input logic [12:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clk);
    reg_req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    // Read data stands only until the next edge, so take it before releasing
    @(negedge clk);
    q = reg_rdata;
    reg_req <= '0;
  endtask : access
endmodule : host_bank_model

// ---- tb/nvm_config_save_restore_test.sv ----
`timescale 1ns/1ps
module nvm_config_save_restore_test;
  import nvm_pkg::*;
  localparam int SV = 4;
  localparam int RS = 3;
  logic clk = 0, rst_n = 0, boot_sel = 0;
  reg_req_t reg_req;
  cfg_wr_t cfg_wr;
  logic [7:0] reg_rdata, cfg_rdata, q;
  logic [15:0] cfg_rd_addr;
  logic cfg_commit, defaults_load, out_sync, out_enable, vco_cal_start;
  logic xfer_busy, status_out_pin_a, i2c_addr_ack;
  int fail_count = 0, compares = 0, cyc = 0, busy_len = 0, vco_n = 0, sync_n = 0, dl_n = 0;

  nvm_config_save_restore #(.DEPTH(64), .SAVE_CYC(SV), .RESTORE_CYC(RS))
    nvm_config_save_restore_i (.clk(clk), .rst_n(rst_n), .boot_sel(boot_sel),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .cfg_rd_addr(cfg_rd_addr),
    .cfg_rdata(cfg_rdata), .cfg_wr(cfg_wr), .cfg_commit(cfg_commit),
    .defaults_load(defaults_load), .out_sync(out_sync), .out_enable(out_enable),
    .vco_cal_start(vco_cal_start), .xfer_busy(xfer_busy),
    .status_out_pin_a(status_out_pin_a), .i2c_addr_ack(i2c_addr_ack));
  host_bank_model host_bank_model_i (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .cfg_rd_addr(cfg_rd_addr), .cfg_rdata(cfg_rdata), .cfg_wr(cfg_wr),
    .cfg_commit(cfg_commit));

  initial begin
    forever #5 clk = ~clk;
  end
  // Pulse counters and a hang guard sized well above the longest test
  always @(posedge clk) begin
    cyc++;
    busy_len += xfer_busy;
    vco_n += vco_cal_start;
    sync_n += out_sync;
    dl_n += defaults_load;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host_bank_model_i.access(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
    host_bank_model_i.access(1'b0, a, 8'h00, q);
    check(q, e);
  endtask : rd_chk
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (xfer_busy !== lvl && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(n < 2000, 1);
  endtask : wait_busy
  task automatic wait_enable;
    int n;
    n = 0;
    while (out_enable !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(n < 400, 1);
  endtask : wait_enable
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    repeat (2) @(negedge clk);
    check(i2c_addr_ack, 1);
    check(dl_n, 1);
    cyc = 0;
    wait_enable();
    check(cyc >= 195 && cyc <= 205, 1);
    // Pulse counters sample on the rising edge after the pulse
    @(negedge clk);
    check(sync_n, 1);
    rd_chk(ADDR_BUSY, 8'h00);
    rd_chk(13'h0B10, 8'h00);
    $display("defaults test done");
  endtask : t_defaults
  task automatic t_refused;
    wr(ADDR_TRIG, 8'h01);
    rd_chk(ADDR_ERROR, 8'h01);
    rd_chk(ADDR_TRIG, 8'h00);
    check(xfer_busy, 0);
    $display("refused test done");
  endtask : t_refused
  task automatic t_save;
    int c0;
    logic [7:0] seg_img [5];
    seg_img = '{8'h01, 8'h00, 8'hF3, 8'h80, 8'hFF};
    host_bank_model_i.bank['h0F3] = 8'h02;
    host_bank_model_i.bank['h0F4] = 8'h5A;
    c0 = host_bank_model_i.commits;
    wr(ADDR_STATUS_SEL, 8'h10);
    wr(ADDR_COMMIT, 8'h01);
    @(negedge clk);
    check(host_bank_model_i.commits, c0 + 1);
    // Two bytes from 0x00F3, commit, end; host order per the write sequence
    foreach (seg_img[i]) wr(ADDR_SEG_BASE + 13'(i), seg_img[i]);
    wr(ADDR_WCTRL, 8'h01);
    busy_len = 0;
    wr(ADDR_TRIG, 8'h01);
    wait_busy(1);
    check({status_out_pin_a, i2c_addr_ack}, 2'b10);
    rd_chk(ADDR_WCTRL, 8'h00);
    rd_chk(ADDR_BUSY, 8'h01);
    wait_busy(0);
    check(busy_len >= 7 * SV, 1);
    rd_chk(ADDR_TRIG, 8'h00);
    rd_chk(ADDR_ERROR, 8'h00);
    wr(ADDR_WCTRL, 8'h00);
    $display("save test done");
  endtask : t_save
  task automatic t_restore(input logic hard);
    int c0;
    c0 = host_bank_model_i.commits;
    host_bank_model_i.wlog.delete();
    vco_n = 0;
    busy_len = 0;
    if (hard) begin
      boot_sel = 1'b1;
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      check(xfer_busy, 1);
    end else wr(ADDR_WCTRL, 8'h02);
    wait_busy(1);
    wait_busy(0);
    wait_enable();
    check(busy_len >= 7 * RS, 1);
    check(host_bank_model_i.wlog.size(), 2);
    check(host_bank_model_i.wlog[0], {1'b1, 16'h00F3, 8'h02});
    check(host_bank_model_i.wlog[1], {1'b1, 16'h00F4, 8'h5A});
    check(host_bank_model_i.commits, c0 + 1);
    check(vco_n, 1);
    rd_chk(ADDR_ERROR, 8'h00);
    $display("restore test done");
  endtask : t_restore
  task automatic t_soft_reset;
    wr(ADDR_SOFT_RESET, 8'h20);
    wait_busy(1);
    wait_busy(0);
    boot_sel = 1'b0;
    $display("soft reset test done");
  endtask : t_soft_reset

  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_defaults();
    t_refused();
    t_save();
    t_restore(1'b0);
    t_restore(1'b1);
    t_soft_reset();
    tally_and_finish();
  end
endmodule : nvm_config_save_restore_test
